// ---- shared/lan_cfg_params.svh ----
// Constants for the function's command, status and revision registers.
// Assumes dword-addressed configuration accesses with four byte enables.
`ifndef LAN_CFG_PARAMS_SVH
`define LAN_CFG_PARAMS_SVH

// Dword indices of the configuration window
`define CFG_DWORD_CMD_STS 6'h01
`define CFG_DWORD_REV 6'h02

// Byte lanes inside the command/status and revision dwords
`define BE_CMD_LO 0
`define BE_CMD_HI 1
`define BE_STS_LO 2
`define BE_STS_HI 3
`define BE_REV 0

// Reset values
`define CMD_RESET 16'h0000
`define STS_RESET 16'h0290
`define PM_CAP_RESET 1'b1

// Command bit positions
`define CMD_IO_SPACE 0
`define CMD_MEM_SPACE 1
`define CMD_MASTER 2
`define CMD_WRITE_INV 4
`define CMD_PARITY_RESP 6
`define CMD_SYSERR 8

// Status bit positions
`define STS_CAPABILITY_LIST_PRESENT 4
`define STS_MASTER_PERR 8
`define STS_TA_RECEIVED 12
`define STS_MA_SEEN 13
`define STS_SYSERR 14
`define STS_PERR_DET 15
`define STS_B2B_TARGET 7
`define STS_SEL_TIMING 9
// Status half sits in the upper sixteen bits of its dword
`define STS_LANE_OFS 16

// Hardwired status fields
`define SEL_TIMING_MEDIUM 2'h1
`define B2B_TARGET_CAPABLE 1'h1

// Revision number base; arbitrary neutral value
`define REV_BASE 8'h00
`define REV_LOW_BITS 3

`endif

// ---- shared/lan_cfg_pkg.sv ----
// Types shared by the command/status register bank and its EEPROM latch.
// Constants live in lan_cfg_params.svh.
package lan_cfg_pkg;

	typedef logic [5:0] cfg_dword_t;
	typedef logic [3:0] cfg_be_t;
	typedef logic [31:0] cfg_data_t;
	typedef logic [2:0] rev_low_t;

	typedef struct packed {
		logic syserr_enable;
		logic parity_response;
		logic write_invalidate_enable;
		logic master_enable;
		logic memory_space_enable;
		logic io_space_enable;
		logic parity_error_detected;
		logic syserr_signaled;
		logic master_abort_seen;
		logic target_abort_received;
		logic master_data_parity_error;
		cfg_data_t rdata;
		logic rvalid;
	} regs_state_t;

	typedef struct packed {
		logic pm_capable;
		logic rev_override;
		rev_low_t rev_low;
	} eeprom_state_t;

endpackage

// ---- core/lan_eeprom_latch.sv ----
// Holds the EEPROM-loaded capability flag and revision override bits.
// Assumes the EEPROM loader runs on clk and pulses load_done once per load.
`timescale 1ns/1ps
`default_nettype none
`include "lan_cfg_params.svh"

module lan_eeprom_latch (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic load_done,
	input wire logic pm_capable_in,
	input wire logic rev_override_in,
	input wire lan_cfg_pkg::rev_low_t rev_low_in,
	output logic pm_capable,
	output logic [7:0] revision
);
	import lan_cfg_pkg::*;

	// Held as a typed constant so its upper bits can be sliced
	localparam logic [7:0] rev_base = `REV_BASE;

	eeprom_state_t state_q;
	eeprom_state_t state_d;

	always_comb begin
		state_d = state_q;
		if (load_done) begin
			state_d.pm_capable = pm_capable_in;
			state_d.rev_override = rev_override_in;
			state_d.rev_low = rev_low_in;
		end
	end

	// Capability reset to one so the status reset value holds before a load
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= '{pm_capable: `PM_CAP_RESET, rev_override: 1'b0, rev_low: 3'h0};
		end else begin
			state_q <= state_d;
		end
	end

	assign pm_capable = state_q.pm_capable;
	assign revision = state_q.rev_override ?
		{rev_base[7:`REV_LOW_BITS], state_q.rev_low} : rev_base;

endmodule
`default_nettype wire

// ---- core/lan_cmd_status_regs.sv ----
// Command, status and revision registers of the LAN function's config space.
// Assumes config accesses and bus events all arrive on clk from the PCI engine.
// Notes on behaviour
// - Command register resets to zero; bits 15 to 10 reserved.
// - Fast back-to-back master enable reads zero; never used.
// - System error pin asserted only while the syserr enable bit is set.
// - Wait cycle, palette snoop, special cycle bits read zero; special cycles ignored.
// - Parity response clear: detected parity errors draw no response action.
// - Parity response set: normal parity action and hub parity generation.
// - Write-and-invalidate used only when its enable bit is set.
// - Bus master activity only while master enable is set.
// - Memory accesses claimed only while memory space enable is set.
// - I/O accesses claimed only while I/O space enable is set.
// - Status register resets to 0290h.
// - Error bits 15,14,13,12,8 sticky; cleared only by writing one.
// - Bit 15 set on any detected parity error, whatever parity response.
// - Bit 14 set whenever the system error pin is asserted.
// - Bit 13 set when a master transaction ends in master abort.
// - Bit 12 set when a master transaction receives target abort.
// - Bit 11 reads zero; target abort never signalled.
// - Bits 10 to 9 report medium select timing, 01.
// - Bit 8 set only as master, parity response on, parity error seen.
// - Bit 7 reads one; bits 6 and 5 read zero.
// - Bit 4 follows the EEPROM power-management capability flag.
// - Read-only 8-bit revision, low three bits overridable from EEPROM.
`timescale 1ns/1ps
`default_nettype none
`include "lan_cfg_params.svh"

module lan_cmd_status_regs (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire lan_cfg_pkg::cfg_dword_t cfg_dword,
	input wire lan_cfg_pkg::cfg_be_t cfg_be,
	input wire lan_cfg_pkg::cfg_data_t cfg_wdata,
	output lan_cfg_pkg::cfg_data_t cfg_rdata,
	output logic cfg_rvalid,
	input wire logic eeprom_load_done,
	input wire logic eeprom_pm_capable,
	input wire logic eeprom_rev_override,
	input wire lan_cfg_pkg::rev_low_t eeprom_rev_low,
	input wire logic parity_error_evt,
	input wire logic syserr_request,
	input wire logic master_abort_evt,
	input wire logic target_abort_evt,
	input wire logic master_perr_evt,
	input wire logic master_request,
	input wire logic write_invalidate_request,
	input wire logic mem_hit,
	input wire logic io_hit,
	input wire logic special_cycle_seen,
	output logic syserr_assert,
	output logic parity_action_enable,
	output logic hub_parity_enable,
	output logic use_write_invalidate,
	output logic master_request_ok,
	output logic b2b_master_enable,
	output logic memory_claim,
	output logic io_claim,
	output logic special_cycle_accept,
	output logic target_abort_drive
);
	import lan_cfg_pkg::*;

	regs_state_t state_q;
	regs_state_t state_d;
	logic pm_capable;
	logic [7:0] revision;
	logic [15:0] command_view;
	logic [15:0] status_view;
	logic wr_cmd_sts;
	logic clr_perr_det;
	logic clr_syserr;
	logic clr_ma;
	logic clr_ta;
	logic clr_mperr;

	lan_eeprom_latch u_eeprom_latch (
		.clk(clk),
		.sys_rst(sys_rst),
		.load_done(eeprom_load_done),
		.pm_capable_in(eeprom_pm_capable),
		.rev_override_in(eeprom_rev_override),
		.rev_low_in(eeprom_rev_low),
		.pm_capable(pm_capable),
		.revision(revision)
	);

	// Read views; reserved and hardwired-zero bits are constant zero
	always_comb begin
		command_view = 16'h0000;
		command_view[`CMD_SYSERR] = state_q.syserr_enable;
		command_view[`CMD_PARITY_RESP] = state_q.parity_response;
		command_view[`CMD_WRITE_INV] = state_q.write_invalidate_enable;
		command_view[`CMD_MASTER] = state_q.master_enable;
		command_view[`CMD_MEM_SPACE] = state_q.memory_space_enable;
		command_view[`CMD_IO_SPACE] = state_q.io_space_enable;
	end

	always_comb begin
		status_view = 16'h0000;
		status_view[`STS_PERR_DET] = state_q.parity_error_detected;
		status_view[`STS_SYSERR] = state_q.syserr_signaled;
		status_view[`STS_MA_SEEN] = state_q.master_abort_seen;
		status_view[`STS_TA_RECEIVED] = state_q.target_abort_received;
		status_view[`STS_SEL_TIMING +: 2] = `SEL_TIMING_MEDIUM;
		status_view[`STS_MASTER_PERR] = state_q.master_data_parity_error;
		status_view[`STS_B2B_TARGET] = `B2B_TARGET_CAPABLE;
		status_view[`STS_CAPABILITY_LIST_PRESENT] = pm_capable;
	end

	// Bus-facing gates; these are handshake terms and stay combinational
	assign syserr_assert = syserr_request && state_q.syserr_enable;
	assign parity_action_enable = state_q.parity_response;
	assign hub_parity_enable = state_q.parity_response;
	assign use_write_invalidate = write_invalidate_request && state_q.write_invalidate_enable &&
		state_q.master_enable;
	assign master_request_ok = master_request && state_q.master_enable;
	assign memory_claim = mem_hit && state_q.memory_space_enable;
	assign io_claim = io_hit && state_q.io_space_enable;
	assign b2b_master_enable = 1'b0;
	// Special cycles are dropped whatever the engine reports
	assign special_cycle_accept = special_cycle_seen && 1'b0;
	assign target_abort_drive = 1'b0;

	assign wr_cmd_sts = cfg_wr && (cfg_dword == `CFG_DWORD_CMD_STS);
	// Write-one-to-clear strobes per sticky bit
	assign clr_perr_det = wr_cmd_sts && cfg_be[`BE_STS_HI] &&
		cfg_wdata[`STS_LANE_OFS + `STS_PERR_DET];
	assign clr_syserr = wr_cmd_sts && cfg_be[`BE_STS_HI] &&
		cfg_wdata[`STS_LANE_OFS + `STS_SYSERR];
	assign clr_ma = wr_cmd_sts && cfg_be[`BE_STS_HI] &&
		cfg_wdata[`STS_LANE_OFS + `STS_MA_SEEN];
	assign clr_ta = wr_cmd_sts && cfg_be[`BE_STS_HI] &&
		cfg_wdata[`STS_LANE_OFS + `STS_TA_RECEIVED];
	assign clr_mperr = wr_cmd_sts && cfg_be[`BE_STS_HI] &&
		cfg_wdata[`STS_LANE_OFS + `STS_MASTER_PERR];

	always_comb begin
		state_d = state_q;
		// Command writes; only writable bits are picked out of the data
		if (wr_cmd_sts && cfg_be[`BE_CMD_LO]) begin
			state_d.parity_response = cfg_wdata[`CMD_PARITY_RESP];
			state_d.write_invalidate_enable = cfg_wdata[`CMD_WRITE_INV];
			state_d.master_enable = cfg_wdata[`CMD_MASTER];
			state_d.memory_space_enable = cfg_wdata[`CMD_MEM_SPACE];
			state_d.io_space_enable = cfg_wdata[`CMD_IO_SPACE];
		end
		if (wr_cmd_sts && cfg_be[`BE_CMD_HI]) begin
			state_d.syserr_enable = cfg_wdata[`CMD_SYSERR];
		end
		// Clear first, then set, so an event in the clearing cycle survives
		if (clr_perr_det) begin
			state_d.parity_error_detected = 1'b0;
		end
		if (clr_syserr) begin
			state_d.syserr_signaled = 1'b0;
		end
		if (clr_ma) begin
			state_d.master_abort_seen = 1'b0;
		end
		if (clr_ta) begin
			state_d.target_abort_received = 1'b0;
		end
		if (clr_mperr) begin
			state_d.master_data_parity_error = 1'b0;
		end
		if (parity_error_evt) begin
			state_d.parity_error_detected = 1'b1;
		end
		if (syserr_assert) begin
			state_d.syserr_signaled = 1'b1;
		end
		if (master_abort_evt) begin
			state_d.master_abort_seen = 1'b1;
		end
		if (target_abort_evt) begin
			state_d.target_abort_received = 1'b1;
		end
		// Only counts while acting as master with parity response on
		if (master_perr_evt && state_q.master_enable && state_q.parity_response) begin
			state_d.master_data_parity_error = 1'b1;
		end
		// Registered read data, one cycle after the request
		state_d.rvalid = cfg_rd;
		if (cfg_rd) begin
			unique case (cfg_dword)
				`CFG_DWORD_CMD_STS: state_d.rdata = {status_view, command_view};
				`CFG_DWORD_REV: state_d.rdata = {24'h000000, revision};
				default: state_d.rdata = 32'h00000000;
			endcase
		end
	end

	// Reset values of command 0000h and status 0290h; fixed bits come from views
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign cfg_rdata = state_q.rdata;
	assign cfg_rvalid = state_q.rvalid;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_syserr_gate;
		syserr_assert |-> state_q.syserr_enable && syserr_request;
	endproperty
	a_syserr_gate: assert property (p_syserr_gate)
		else $error("System error asserted while disabled");

	property p_syserr_sticky;
		syserr_assert |=> state_q.syserr_signaled;
	endproperty
	a_syserr_sticky: assert property (p_syserr_sticky)
		else $error("Signalled system error bit not set");

	property p_perr_any;
		parity_error_evt && !state_q.parity_response |=> state_q.parity_error_detected;
	endproperty
	a_perr_any: assert property (p_perr_any)
		else $error("Detected parity bit missed with response off");

	property p_mperr_gated;
		!state_q.master_data_parity_error && !(master_perr_evt && state_q.master_enable &&
			state_q.parity_response) |=> !state_q.master_data_parity_error;
	endproperty
	a_mperr_gated: assert property (p_mperr_gated)
		else $error("Master parity bit set without its conditions");

	property p_w1c_clear;
		clr_ma && !master_abort_evt |=> !state_q.master_abort_seen;
	endproperty
	a_w1c_clear: assert property (p_w1c_clear)
		else $error("Write one did not clear master abort bit");

	property p_sticky_hold;
		state_q.target_abort_received && !clr_ta |=> state_q.target_abort_received;
	endproperty
	a_sticky_hold: assert property (p_sticky_hold)
		else $error("Target abort bit lost without clear");

	property p_set_wins;
		clr_perr_det && parity_error_evt |=> state_q.parity_error_detected;
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("Parity event lost in clearing cycle");

	property p_sts_fixed;
		cfg_rd && cfg_dword == `CFG_DWORD_CMD_STS |=>
			cfg_rvalid && cfg_rdata[26:25] == `SEL_TIMING_MEDIUM && !cfg_rdata[27] &&
			cfg_rdata[23] && cfg_rdata[22:21] == 2'h0 && cfg_rdata[19:16] == 4'h0;
	endproperty
	a_sts_fixed: assert property (p_sts_fixed)
		else $error("Hardwired status bits read wrong");

	property p_cmd_fixed;
		cfg_rd && cfg_dword == `CFG_DWORD_CMD_STS |=>
			cfg_rdata[15:9] == 7'h00 && !cfg_rdata[7] && !cfg_rdata[5] && !cfg_rdata[3];
	endproperty
	a_cmd_fixed: assert property (p_cmd_fixed)
		else $error("Hardwired command bits read nonzero");

	property p_claims;
		(memory_claim |-> state_q.memory_space_enable) and
			(io_claim |-> state_q.io_space_enable);
	endproperty
	a_claims: assert property (p_claims)
		else $error("Access claimed while space disabled");

	property p_master_gate;
		(master_request_ok || use_write_invalidate) |-> state_q.master_enable;
	endproperty
	a_master_gate: assert property (p_master_gate)
		else $error("Master activity while master disabled");

	property p_mwi_gate;
		use_write_invalidate |-> state_q.write_invalidate_enable;
	endproperty
	a_mwi_gate: assert property (p_mwi_gate)
		else $error("Write-and-invalidate used while disabled");

	property p_rev_read;
		cfg_rd && cfg_dword == `CFG_DWORD_REV |=>
			cfg_rvalid && cfg_rdata == {24'h0, $past(revision)};
	endproperty
	a_rev_read: assert property (p_rev_read)
		else $error("Revision read mismatch");

	// Master and I/O space enable bits must take the written low lane value
	property p_cmd_write;
		wr_cmd_sts && cfg_be[`BE_CMD_LO] |=>
			state_q.master_enable == $past(cfg_wdata[`CMD_MASTER]) &&
			state_q.io_space_enable == $past(cfg_wdata[`CMD_IO_SPACE]);
	endproperty
	a_cmd_write: assert property (p_cmd_write)
		else $error("Command low byte write did not land");

	property p_syserr_en_write;
		wr_cmd_sts && cfg_be[`BE_CMD_HI] |=>
			state_q.syserr_enable == $past(cfg_wdata[`CMD_SYSERR]);
	endproperty
	a_syserr_en_write: assert property (p_syserr_en_write)
		else $error("System error enable write did not land");

	property p_ma_set;
		master_abort_evt |=> state_q.master_abort_seen;
	endproperty
	a_ma_set: assert property (p_ma_set)
		else $error("Master abort bit not set");

	property p_ta_set;
		target_abort_evt |=> state_q.target_abort_received;
	endproperty
	a_ta_set: assert property (p_ta_set)
		else $error("Received target abort bit not set");

	// A written zero must leave a set bit alone
	property p_ma_hold;
		state_q.master_abort_seen && !clr_ma |=> state_q.master_abort_seen;
	endproperty
	a_ma_hold: assert property (p_ma_hold)
		else $error("Master abort bit lost without clear");

	property p_cap_read;
		cfg_rd && cfg_dword == `CFG_DWORD_CMD_STS |=>
			cfg_rdata[`STS_LANE_OFS + `STS_CAPABILITY_LIST_PRESENT] == $past(pm_capable);
	endproperty
	a_cap_read: assert property (p_cap_read)
		else $error("Capability bit does not follow the EEPROM flag");

	property p_hardwired_outs;
		!b2b_master_enable && !special_cycle_accept && !target_abort_drive;
	endproperty
	a_hardwired_outs: assert property (p_hardwired_outs)
		else $error("Hardwired-off bus output went high");

	c_w1c_and_event: cover property (clr_ta && target_abort_evt);
	c_syserr_fire: cover property (syserr_assert ##1 clr_syserr);
	c_mperr_set: cover property (master_perr_evt && state_q.master_enable &&
		state_q.parity_response);
	c_io_claim: cover property (io_claim ##1 memory_claim);

endmodule
`default_nettype wire

// ---- dv/cfg_host_model.sv ----
// Host model: configuration software issuing dword reads and writes.
// Assumes the bank raises cfg_rvalid at the same clock edge that takes the read.
`timescale 1ns/1ps
`default_nettype none

module cfg_host_model (
	input wire logic clk,
	input wire lan_cfg_pkg::cfg_data_t cfg_rdata,
	input wire logic cfg_rvalid,
	output logic cfg_wr,
	output logic cfg_rd,
	output lan_cfg_pkg::cfg_dword_t cfg_dword,
	output lan_cfg_pkg::cfg_be_t cfg_be,
	output lan_cfg_pkg::cfg_data_t cfg_wdata
);
	import lan_cfg_pkg::*;

	initial begin
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_dword = 6'h3f;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
	end

	// Idle lanes carry the inverse, so a stale value never looks live
	task automatic wr(input cfg_dword_t d, input cfg_be_t be, input cfg_data_t v);
		@(posedge clk);
		#1;
		cfg_wr = 1'b1;
		cfg_dword = d;
		cfg_be = be;
		cfg_wdata = v;
		@(posedge clk);
		#1;
		cfg_wr = 1'b0;
		cfg_dword = ~d;
		cfg_be = ~be;
		cfg_wdata = ~v;
	endtask

	task automatic rd(input cfg_dword_t d, output cfg_data_t v, output logic ok);
		ok = 1'b0;
		v = 32'h0;
		@(posedge clk);
		#1;
		cfg_rd = 1'b1;
		cfg_dword = d;
		cfg_be = 4'hf;
		@(posedge clk);
		#1;
		cfg_rd = 1'b0;
		cfg_dword = ~d;
		for (int i = 0; i < 4 && !ok; i++) begin
			if (cfg_rvalid === 1'b1) begin
				ok = 1'b1;
				v = cfg_rdata;
			end else begin
				@(posedge clk);
				#1;
			end
		end
	endtask
endmodule

`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the command, status and revision register bank.
// Assumes the host model drives the config port; bus events come from here.
`timescale 1ns/1ps
`default_nettype none
`include "lan_cfg_params.svh"

module testbench;
	import lan_cfg_pkg::*;

	typedef struct packed {
		logic [15:0] w;
		logic [15:0] e;
	} row_t;

	logic clk;
	logic sys_rst;
	logic cfg_wr;
	logic cfg_rd;
	cfg_dword_t cfg_dword;
	cfg_be_t cfg_be;
	cfg_data_t cfg_wdata;
	cfg_data_t cfg_rdata;
	logic cfg_rvalid;
	logic ee_load, ee_pm, ee_ovr;
	rev_low_t ee_low;
	logic [4:0] ev;
	logic [4:0] lv;
	logic syserr_assert, parity_action_enable, hub_parity_enable, use_write_invalidate;
	logic master_request_ok, b2b_master_enable, memory_claim, io_claim;
	logic special_cycle_accept, target_abort_drive;
	int n_errors = 0;
	int n_compared = 0;
	row_t rows [6] = '{'{16'hffff, 16'h0157}, '{16'h02a8, 16'h0000}, '{16'h0115, 16'h0115},
		'{16'h0042, 16'h0042}, '{16'h0004, 16'h0004}, '{16'h0010, 16'h0010}};
	int pos [5] = '{15, 14, 13, 12, 8};

	cfg_host_model host (.clk(clk), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_dword(cfg_dword), .cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata));

	lan_cmd_status_regs DUT (.clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_dword(cfg_dword), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.cfg_rvalid(cfg_rvalid), .eeprom_load_done(ee_load), .eeprom_pm_capable(ee_pm),
		.eeprom_rev_override(ee_ovr), .eeprom_rev_low(ee_low), .parity_error_evt(ev[0]),
		.syserr_request(ev[1]), .master_abort_evt(ev[2]), .target_abort_evt(ev[3]),
		.master_perr_evt(ev[4]), .master_request(lv[0]), .write_invalidate_request(lv[1]),
		.mem_hit(lv[2]), .io_hit(lv[3]), .special_cycle_seen(lv[4]),
		.syserr_assert(syserr_assert), .parity_action_enable(parity_action_enable),
		.hub_parity_enable(hub_parity_enable), .use_write_invalidate(use_write_invalidate),
		.master_request_ok(master_request_ok), .b2b_master_enable(b2b_master_enable),
		.memory_claim(memory_claim), .io_claim(io_claim),
		.special_cycle_accept(special_cycle_accept), .target_abort_drive(target_abort_drive));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic tally_and_finish;
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic rdchk(input string nm, input cfg_dword_t d, input cfg_data_t e);
		cfg_data_t v;
		logic ok;
		host.rd(d, v, ok);
		if (ok !== 1'b1) begin
			n_errors++;
			$display("wrong value %s expected read answer seen none", nm);
			tally_and_finish();
		end else begin
			check(nm, v, e);
		end
	endtask

	// Sample syserr_assert mid-pulse, after the combinational gate settles
	task automatic pulse(input int k, output logic sa);
		@(posedge clk);
		#1;
		ev[k] = 1'b1;
		#5;
		sa = syserr_assert;
		@(posedge clk);
		#1;
		ev[k] = 1'b0;
	endtask

	initial begin
		logic sa;
		logic [15:0] st;
		logic [7:0] rev;
		sys_rst = 1'b1;
		ee_load = 1'b0;
		ee_pm = 1'b0;
		ee_ovr = 1'b0;
		ee_low = 3'h0;
		ev = 5'h00;
		lv = 5'h1f;
		repeat (10) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		rdchk("cmd status reset", 6'h01, 32'h0290_0000);
		rdchk("revision reset", 6'h02, {24'h0, `REV_BASE});
		rdchk("unmapped", 6'h03, 32'h0);
		$display("test reset done");

		foreach (rows[i]) begin
			host.wr(6'h01, 4'h3, {16'hffff, rows[i].w});
			// Request only once the new enable stands, so a stale enable sets nothing
			ev[1] = 1'b1;
			rdchk("cmd", 6'h01, {16'h0290 | (rows[i].e[8] ? 16'h4000 : 16'h0), rows[i].e});
			check("syserr_assert", syserr_assert, rows[i].e[8]);
			check("parity_action", parity_action_enable, rows[i].e[6]);
			check("hub_parity", hub_parity_enable, rows[i].e[6]);
			check("write_inv", use_write_invalidate, rows[i].e[4] & rows[i].e[2]);
			check("master_ok", master_request_ok, rows[i].e[2]);
			check("mem_claim", memory_claim, rows[i].e[1]);
			check("io_claim", io_claim, rows[i].e[0]);
			check("fixed zeros", {b2b_master_enable, special_cycle_accept, target_abort_drive}, 0);
			// Request dropped before the clear, else the set would win
			ev[1] = 1'b0;
			host.wr(6'h01, 4'h8, 32'hff00_0000);
		end
		ev[1] = 1'b0;
		host.wr(6'h01, 4'h8, 32'hff00_0000);
		$display("test command rows done");

		st = 16'h0290;
		host.wr(6'h01, 4'h3, 32'h0000_0144);
		for (int k = 0; k < 5; k++) begin
			pulse(k, sa);
			check("syserr mid pulse", sa, k == 1);
			st = st | (16'h1 << pos[k]);
			rdchk("status set", 6'h01, {st, 16'h0144});
		end
		// Lane 2 ones and lane 3 one-hot: only the written bit may drop
		for (int k = 0; k < 5; k++) begin
			host.wr(6'h01, 4'hc, {8'h01 << (pos[k] - 8), 8'hff, 16'h0});
			st = st & ~(16'h1 << pos[k]);
			rdchk("status clear", 6'h01, {st, 16'h0144});
		end
		$display("test sticky status done");

		host.wr(6'h01, 4'h3, 32'h0000_0040);
		pulse(4, sa);
		rdchk("perr not master", 6'h01, 32'h0290_0040);
		host.wr(6'h01, 4'h3, 32'h0);
		pulse(1, sa);
		check("syserr disabled", sa, 1'b0);
		rdchk("no syserr status", 6'h01, 32'h0290_0000);
		pulse(0, sa);
		check("parity ignored", parity_action_enable, 1'b0);
		rdchk("parity always seen", 6'h01, 32'h8290_0000);
		$display("test refusals done");

		// Event high through its own clear: the event must win
		ev[0] = 1'b1;
		ev[3] = 1'b1;
		host.wr(6'h01, 4'h8, 32'h9000_0000);
		ev[0] = 1'b0;
		ev[3] = 1'b0;
		rdchk("set beats clear", 6'h01, 32'h9290_0000);
		host.wr(6'h01, 4'h8, 32'h1000_0000);
		rdchk("clear one bit", 6'h01, 32'h8290_0000);
		$display("test set wins done");

		@(posedge clk);
		#1;
		ee_load = 1'b1;
		ee_ovr = 1'b1;
		ee_low = 3'h5;
		@(posedge clk);
		#1;
		ee_load = 1'b0;
		rev = {`REV_BASE & 8'hf8} | 8'h05;
		host.wr(6'h02, 4'hf, 32'hffff_ffff);
		rdchk("revision override", 6'h02, {24'h0, rev});
		rdchk("cap bit off", 6'h01, 32'h8280_0000);
		$display("test eeprom done");

		host.wr(6'h01, 4'h3, 32'h0000_0157);
		@(posedge clk);
		#1;
		sys_rst = 1'b1;
		@(posedge clk);
		#1;
		sys_rst = 1'b0;
		rdchk("second reset", 6'h01, 32'h0290_0000);
		check("gates after reset", {master_request_ok, use_write_invalidate, memory_claim,
			io_claim, hub_parity_enable}, 0);
		$display("test second reset done");
		tally_and_finish();
	end
endmodule

`default_nettype wire
